// *** inc/bmad_pkg.sv ***
package bmad_pkg;

   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int BANK_W = 4;
   localparam int NUM_CS = 8;
   localparam int NUM_MASTERS = 3;
   localparam int EXT_ADDR_W = 26;
   localparam logic [3:0] BANK_INTERNAL = 4'h0;
   localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
   localparam logic [3:0] BANK_EXT_LAST = 4'h8;
   localparam logic [3:0] BANK_PERIPH = 4'hF;
   // Boot region covers the lowest 1M bytes of bank zero
   localparam logic [31:0] BOOT_REGION_LAST = 32'h000F_FFFF;
   localparam logic [31:0] INT_AREA_LAST = 32'h000F_FFFF;
   // Second-level split of the internal area
   localparam logic [31:0] SRAM0_BASE = 32'h0020_0000;
   localparam logic [31:0] SRAM0_SIZE = 32'h0001_8000;
   localparam logic [31:0] SRAM1_BASE = 32'h0030_0000;
   localparam logic [31:0] SRAM1_SIZE = 32'h0001_0000;
   localparam logic [31:0] ROM_BASE = 32'h0040_0000;
   localparam logic [31:0] ROM_SIZE = 32'h0004_0000;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic RST_BOOT_SEL = 1'b0;
   localparam logic RST_REMAP = 1'b0;
   localparam logic [7:0] RST_CS_ASSIGN = 8'h00;
   localparam logic [1:0] SMC_BUS_16 = 2'h1;

   // ------------------------------------------------------------
   // AHB encodings
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_BUSY = 2'h1;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic HRESP_ERROR = 1'b1;

   typedef enum logic [3:0] {
      BMAD_TGT_NONE,
      BMAD_TGT_SRAM0,
      BMAD_TGT_SRAM1,
      BMAD_TGT_ROM,
      BMAD_TGT_EXT,
      BMAD_TGT_PERIPH,
      BMAD_TGT_ABORT
   } bmad_target_t;

   // One master's address-phase request
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic hready;
   } bmad_req_t;

   // Decoder result for one master
   typedef struct packed {
      bmad_target_t target;
      logic [2:0] cs_index;
      logic [25:0] ext_addr;
   } bmad_sel_t;

   // Static memory controller defaults for chip select zero
   typedef struct packed {
      logic byte_select;
      logic [1:0] bus_width;
      logic rw_by_cs;
   } bmad_smc_cfg_t;

endpackage

// *** core/bmad_decode.sv ***
`timescale 1ns/1ns
module bmad_decode (
   input wire logic [31:0] haddr_i,
   input wire logic is_cpu_i,
   input wire logic boot_internal_i,
   input wire logic remap_i,
   output bmad_pkg::bmad_sel_t sel_o
);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] s);
      in_win = (a >= b) && (a < (b + s));
   endfunction

   wire logic [3:0] bank = haddr_i[31:28];
   wire logic in_boot = (haddr_i <= bmad_pkg::BOOT_REGION_LAST);
   wire logic is_ext = (bank >= bmad_pkg::BANK_EXT_FIRST) &&
                       (bank <= bmad_pkg::BANK_EXT_LAST);
   wire logic [3:0] cs_full = bank - bmad_pkg::BANK_EXT_FIRST;
   bmad_pkg::bmad_target_t boot_tgt;
   bmad_pkg::bmad_target_t int_tgt;
   bmad_pkg::bmad_target_t tgt;

   // Boot region target: remap, internal or external boot
   always_comb begin
      if (remap_i) begin
         boot_tgt = bmad_pkg::BMAD_TGT_SRAM0;
      end else if (!is_cpu_i) begin
         boot_tgt = bmad_pkg::BMAD_TGT_ROM;
      end else if (boot_internal_i) begin
         boot_tgt = bmad_pkg::BMAD_TGT_ROM;
      end else begin
         boot_tgt = bmad_pkg::BMAD_TGT_EXT;
      end
   end

   // Second-level split of bank zero
   always_comb begin
      if (in_boot) begin
         int_tgt = boot_tgt;
      end else if (in_win(haddr_i, bmad_pkg::SRAM0_BASE, bmad_pkg::SRAM0_SIZE)) begin
         int_tgt = bmad_pkg::BMAD_TGT_SRAM0;
      end else if (in_win(haddr_i, bmad_pkg::SRAM1_BASE, bmad_pkg::SRAM1_SIZE)) begin
         int_tgt = bmad_pkg::BMAD_TGT_SRAM1;
      end else if (in_win(haddr_i, bmad_pkg::ROM_BASE, bmad_pkg::ROM_SIZE)) begin
         int_tgt = bmad_pkg::BMAD_TGT_ROM;
      end else begin
         int_tgt = bmad_pkg::BMAD_TGT_ABORT;
      end
   end

   // First-level bank select
   always_comb begin
      if (bank == bmad_pkg::BANK_INTERNAL) begin
         tgt = int_tgt;
      end else if (is_ext) begin
         tgt = bmad_pkg::BMAD_TGT_EXT;
      end else if (bank == bmad_pkg::BANK_PERIPH) begin
         tgt = bmad_pkg::BMAD_TGT_PERIPH;
      end else begin
         tgt = bmad_pkg::BMAD_TGT_ABORT;
      end
   end

   assign sel_o.target = tgt;
   // External boot uses chip select zero
   assign sel_o.cs_index = is_ext ? cs_full[2:0] : 3'h0;
   assign sel_o.ext_addr = haddr_i[25:0];

endmodule // bmad_decode

// *** core/bmad_matrix_decoder.sv ***
`timescale 1ns/1ns
// Behaviour
// - Address space split into sixteen 256M banks by upper four bits.
// - Banks one to eight drive external chip selects zero to seven.
// - Bank zero holds internal memories with a 1M internal area.
// - Bank fifteen goes to the peripheral bridge.
// - Unused banks nine to fourteen abort.
// - Each master has its own path and decoder, identical except that only master zero can boot external.
// - Processor address zero maps to internal or external boot slave.
// - Boot region spans zero to 0x000FFFFF.
// - Boot select low maps the processor's boot region to chip select zero; masters one and two get internal ROM.
// - Boot select high maps boot region to internal ROM.
// - Chip select zero defaults to byte select, 16-bit, chip-select qualified.
// - Both SRAM blocks are separate single-cycle slaves.
// - Alternative controller per select fixed: SDRAM on one, NAND on three, card on four and five.
// - Controller choice per chip select set by software configuration.
// - External address is 26 bits, 64M per chip select.
// - Boot select pin sampled at reset and held.
// - Remap command puts internal SRAM in the boot region.
module bmad_matrix_decoder (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic boot_select_pin_i,
   input wire logic remap_cmd_i,
   input wire logic [7:0] cs_assign_i,
   input bmad_pkg::bmad_req_t [2:0] req_i,
   output logic [2:0] sel_sram0_o,
   output logic [2:0] sel_sram1_o,
   output logic [2:0] sel_rom_o,
   output logic [2:0] sel_ext_o,
   output logic [2:0] sel_periph_o,
   output logic [8:0] cs_index_o,
   output logic [77:0] ext_addr_o,
   output logic [7:0] ext_chip_select_n_o,
   output logic sdram_chip_select_n_o,
   output logic [7:0] nand_enable_o,
   output logic [7:0] card_enable_o,
   output logic [2:0] hresp_o,
   output logic [2:0] hready_o,
   output bmad_pkg::bmad_smc_cfg_t smc_cs0_cfg_o,
   output logic boot_internal_o,
   output logic remap_o
);

   // ------------------------------------------------------------
   // Boot select capture
   // ------------------------------------------------------------
   logic boot_sync1;
   logic boot_sync2;
   logic [1:0] boot_settle;
   logic boot_latched;
   logic boot_sel;
   logic remap;
   // Error response phases of one master
   typedef enum logic [1:0] {
      ERR_IDLE,
      ERR_FIRST,
      ERR_SECOND
   } bmad_err_t;
   bmad_err_t err_phase [3];
   bmad_pkg::bmad_sel_t dsel [3];

   // Pin synchroniser
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_sync1 <= bmad_pkg::RST_BOOT_SEL;
         boot_sync2 <= bmad_pkg::RST_BOOT_SEL;
      end else begin
         boot_sync1 <= boot_select_pin_i;
         boot_sync2 <= boot_sync1;
      end
   end

   // Wait until the second stage holds a real pin sample, capture it once, then hold
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_settle <= 2'h0;
         boot_latched <= 1'b0;
         boot_sel <= bmad_pkg::RST_BOOT_SEL;
      end else if (!boot_latched) begin
         boot_settle <= {boot_settle[0], 1'b1};
         boot_latched <= boot_settle[1];
         boot_sel <= boot_sync2;
      end
   end

   // Remap command is sticky until reset
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remap <= bmad_pkg::RST_REMAP;
      end else if (remap_cmd_i) begin
         remap <= 1'b1;
      end
   end

   assign boot_internal_o = boot_sel;
   assign remap_o = remap;
   // Static controller reset defaults for chip select zero
   assign smc_cs0_cfg_o.byte_select = 1'b1;
   assign smc_cs0_cfg_o.bus_width = bmad_pkg::SMC_BUS_16;
   assign smc_cs0_cfg_o.rw_by_cs = 1'b1;

   // ------------------------------------------------------------
   // Per-master decoders
   // ------------------------------------------------------------
   genvar m;
   generate
      for (m = 0; m < 3; m++) begin : g_master
         wire logic active = req_i[m].htrans[1] && req_i[m].hready;
         wire logic is_abort = active &&
                               (dsel[m].target == bmad_pkg::BMAD_TGT_ABORT);

         // Same map for every master except the boot region, where only master zero, the processor, can boot external
         bmad_decode u_dec (
            .haddr_i(req_i[m].haddr),
            .is_cpu_i(m == 0),
            .boot_internal_i(boot_sel),
            .remap_i(remap),
            .sel_o(dsel[m])
         );

         // No slave selected on abort
         assign sel_sram0_o[m] = active && dsel[m].target == bmad_pkg::BMAD_TGT_SRAM0;
         assign sel_sram1_o[m] = active && dsel[m].target == bmad_pkg::BMAD_TGT_SRAM1;
         assign sel_rom_o[m] = active && dsel[m].target == bmad_pkg::BMAD_TGT_ROM;
         assign sel_ext_o[m] = active && dsel[m].target == bmad_pkg::BMAD_TGT_EXT;
         assign sel_periph_o[m] = active && dsel[m].target == bmad_pkg::BMAD_TGT_PERIPH;
         assign cs_index_o[m*3 +: 3] = dsel[m].cs_index;
         assign ext_addr_o[m*26 +: 26] = dsel[m].ext_addr;

         // Two-cycle ERROR response: first cycle holds ready low, second raises it
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               err_phase[m] <= ERR_IDLE;
            end else begin
               case (err_phase[m])
                  ERR_FIRST: err_phase[m] <= ERR_SECOND;
                  ERR_IDLE, ERR_SECOND: err_phase[m] <= is_abort ? ERR_FIRST : ERR_IDLE;
                  default: err_phase[m] <= ERR_IDLE;
               endcase
            end
         end

         assign hresp_o[m] = (err_phase[m] != ERR_IDLE) ? bmad_pkg::HRESP_ERROR
                                                        : bmad_pkg::HRESP_OKAY;
         assign hready_o[m] = (err_phase[m] != ERR_FIRST);
      end
   endgenerate

   // ------------------------------------------------------------
   // External chip selects (master zero has priority)
   // ------------------------------------------------------------
   wire logic [1:0] ext_win = sel_ext_o[0] ? 2'h0 : (sel_ext_o[1] ? 2'h1 : 2'h2);
   wire logic ext_any = |sel_ext_o;
   wire logic [2:0] ext_cs = cs_index_o[ext_win*3 +: 3];
   wire logic [7:0] cs_onehot = ext_any ? (8'h01 << ext_cs) : 8'h00;
   // Chip select one may be claimed by SDRAM via configuration
   wire logic cs1_sdram = cs_assign_i[1];

   assign ext_chip_select_n_o = ~(cs_onehot & ~{6'h00, cs1_sdram, 1'b0});
   assign sdram_chip_select_n_o = ~(cs_onehot[1] & cs1_sdram);
   assign nand_enable_o = cs_onehot & {4'h0, cs_assign_i[3], 3'h0};
   assign card_enable_o = cs_onehot & {2'h0, cs_assign_i[5:4], 4'h0};

endmodule // bmad_matrix_decoder

// *** test/bmad_matrix_decoder_properties.sv ***
`timescale 1ns/1ns
// Decoder checker, ports named as on the decoder top
module bmad_chk (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic remap_cmd_i,
   input bmad_pkg::bmad_req_t [2:0] req_i,
   input wire logic [2:0] sel_sram0_o,
   input wire logic [2:0] sel_sram1_o,
   input wire logic [2:0] sel_rom_o,
   input wire logic [2:0] sel_ext_o,
   input wire logic [2:0] sel_periph_o,
   input wire logic [8:0] cs_index_o,
   input wire logic [77:0] ext_addr_o,
   input wire logic [2:0] hresp_o,
   input wire logic [2:0] hready_o,
   input bmad_pkg::bmad_smc_cfg_t smc_cs0_cfg_o,
   input wire logic boot_internal_o,
   input wire logic remap_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // Bank numbers of each master
   wire logic [3:0] b0 = req_i[0].haddr[31:28];
   wire logic [3:0] b1 = req_i[1].haddr[31:28];
   wire logic [3:0] b2 = req_i[2].haddr[31:28];
   wire logic boot0 = req_i[0].haddr <= bmad_pkg::BOOT_REGION_LAST;
   // Address phases taken from masters zero and two
   wire logic act0 = req_i[0].htrans[1] && req_i[0].hready;
   wire logic act2 = req_i[2].htrans[1] && req_i[2].hready;
   property p_periph;
      act0 && b0 == 4'hF |-> sel_periph_o[0];
   endproperty
   a_periph: assert property (p_periph) else $error("periph select missing");
   property p_abort;
      req_i[0].htrans[1] && req_i[0].hready && b0 inside {[4'h9:4'hE]}
         |=> hresp_o[0] && !hready_o[0] ##1 hresp_o[0] && hready_o[0];
   endproperty
   a_abort: assert property (p_abort) else $error("error response wrong");
   property p_none;
      b2 inside {[4'h9:4'hE]} |-> !(sel_sram0_o[2] || sel_sram1_o[2] || sel_rom_o[2]
         || sel_ext_o[2] || sel_periph_o[2]);
   endproperty
   a_none: assert property (p_none) else $error("slave selected on hole");
   property p_ext;
      act2 && b2 inside {[4'h1:4'h8]} |-> sel_ext_o[2] && cs_index_o[8:6] == b2[2:0] - 3'h1;
   endproperty
   a_ext: assert property (p_ext) else $error("chip select index wrong");
   property p_eaddr;
      b1 inside {[4'h1:4'h8]} |-> ext_addr_o[51:26] == req_i[1].haddr[25:0];
   endproperty
   a_eaddr: assert property (p_eaddr) else $error("external address wrong");
   property p_boot;
      act0 && boot0 && !remap_o |-> (boot_internal_o ? sel_rom_o[0]
         : sel_ext_o[0] && cs_index_o[2:0] == 3'h0);
   endproperty
   a_boot: assert property (p_boot) else $error("boot region target wrong");
   property p_hold;
      boot_internal_o |=> boot_internal_o;
   endproperty
   a_hold: assert property (p_hold) else $error("boot select not held");
   property p_remap;
      remap_cmd_i || remap_o |=> remap_o && (!(act0 && boot0) || sel_sram0_o[0]);
   endproperty
   a_remap: assert property (p_remap) else $error("remap lost or ignored");
   property p_cfg;
      smc_cs0_cfg_o == {1'b1, bmad_pkg::SMC_BUS_16, 1'b1};
   endproperty
   a_cfg: assert property (p_cfg) else $error("cs0 defaults wrong");
endmodule // bmad_chk
bind bmad_matrix_decoder bmad_chk i_chk (
   .clock_i(clock_i),
   .rstn_i(rstn_i),
   .remap_cmd_i(remap_cmd_i),
   .req_i(req_i),
   .sel_sram0_o(sel_sram0_o),
   .sel_sram1_o(sel_sram1_o),
   .sel_rom_o(sel_rom_o),
   .sel_ext_o(sel_ext_o),
   .sel_periph_o(sel_periph_o),
   .cs_index_o(cs_index_o),
   .ext_addr_o(ext_addr_o),
   .hresp_o(hresp_o),
   .hready_o(hready_o),
   .smc_cs0_cfg_o(smc_cs0_cfg_o),
   .boot_internal_o(boot_internal_o),
   .remap_o(remap_o)
);

// *** test/bmad_master_model.sv ***
`timescale 1ns/1ns
// Behavioural bus master: a NONSEQ address phase on every cycle while valid
module bmad_master_model (
   input wire logic [31:0] addr_i,
   input wire logic valid_i,
   input wire logic hready_i,
   output bmad_pkg::bmad_req_t req_o
);
   // Idle lines show the inverted address, never a stale copy
   assign req_o = '{haddr: valid_i ? addr_i : ~addr_i, hwrite: 1'b0, hready: hready_i,
      htrans: valid_i ? 2'h2 : bmad_pkg::HTRANS_IDLE};
endmodule // bmad_master_model

// *** test/bmad_matrix_decoder_bench.sv ***
`timescale 1ns/1ns
module bmad_matrix_decoder_bench;
   logic clock_i = 1'b0, rstn_i = 1'b0, boot_select_pin_i = 1'b0, remap_cmd_i = 1'b0;
   logic [7:0] cs_assign_i = 8'h00;
   logic [31:0] addr [3] = '{default: 32'h0};
   logic [2:0] vld = 3'h0;
   wire bmad_pkg::bmad_req_t [2:0] req_i;
   logic [2:0] sel_sram0_o, sel_sram1_o, sel_rom_o, sel_ext_o, sel_periph_o, hresp_o, hready_o;
   logic [8:0] cs_index_o;
   logic [77:0] ext_addr_o;
   logic [7:0] ext_chip_select_n_o, nand_enable_o, card_enable_o;
   logic sdram_chip_select_n_o, boot_internal_o, remap_o;
   bmad_pkg::bmad_smc_cfg_t smc_cs0_cfg_o;
   int failures = 0, num_checks = 0, cyc = 0;
   // Clock and the three masters
   always #25 clock_i = ~clock_i;
   for (genvar m = 0; m < 3; m++) begin : g_m
      bmad_master_model i_bmad_master_model (.addr_i(addr[m]), .valid_i(vld[m]),
         .hready_i(hready_o[m]), .req_o(req_i[m]));
   end
   bmad_matrix_decoder i_bmad_matrix_decoder (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .boot_select_pin_i(boot_select_pin_i),
      .remap_cmd_i(remap_cmd_i),
      .cs_assign_i(cs_assign_i),
      .req_i(req_i),
      .sel_sram0_o(sel_sram0_o),
      .sel_sram1_o(sel_sram1_o),
      .sel_rom_o(sel_rom_o),
      .sel_ext_o(sel_ext_o),
      .sel_periph_o(sel_periph_o),
      .cs_index_o(cs_index_o),
      .ext_addr_o(ext_addr_o),
      .ext_chip_select_n_o(ext_chip_select_n_o),
      .sdram_chip_select_n_o(sdram_chip_select_n_o),
      .nand_enable_o(nand_enable_o),
      .card_enable_o(card_enable_o),
      .hresp_o(hresp_o),
      .hready_o(hready_o),
      .smc_cs0_cfg_o(smc_cs0_cfg_o),
      .boot_internal_o(boot_internal_o),
      .remap_o(remap_o)
   );
   // ----
   // Helpers
   // ----
   task chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   function logic [4:0] sv(int m);
      return {sel_sram0_o[m], sel_sram1_o[m], sel_rom_o[m], sel_ext_o[m], sel_periph_o[m]};
   endfunction
   task step;
      @(posedge clock_i);
      #5;
   endtask
   task go(int m, logic [31:0] a);
      addr[m] = a;
      vld[m] = 1'b1;
      #1;
   endtask
   task rst(logic pin);
      rstn_i = 1'b0;
      boot_select_pin_i = pin;
      repeat (8) step;
      rstn_i = 1'b1;
      repeat (4) step;
   endtask
   // ----
   // Scenarios
   // ----
   task t_map;
      logic [4:0] e;
      for (int b = 0; b < 16; b++) begin
         e = b == 0 ? 5'h10 : b == 15 ? 5'h01 : b < 9 ? 5'h02 : 5'h00;
         go(b % 3, {b[3:0], 28'h0200124});
         chk("sel", e, sv(b % 3));
         if (b inside {[1:8]}) chk("cs", b - 1, cs_index_o[(b % 3) * 3 +: 3]);
         chk("ea", 26'h0200124, ext_addr_o[(b % 3) * 26 +: 26]);
         step;
         vld = 3'h0;
      end
   endtask
   task t_abort;
      // Let the error left by the mapping sweep finish first
      repeat (2) step;
      go(2, 32'hEFFF_FFFC);
      step;
      vld = 3'h0;
      chk("err1", 2'h2, {hresp_o[2], hready_o[2]});
      chk("other", 2'h1, {hresp_o[0], hready_o[0]});
      step;
      chk("err2", 2'h3, {hresp_o[2], hready_o[2]});
      step;
      chk("err3", 2'h1, {hresp_o[2], hready_o[2]});
   endtask
   task t_inner;
      logic [31:0] ta [8] = '{32'h0020_0000, 32'h0021_7FFF, 32'h0021_8000, 32'h0030_FFFF,
         32'h0031_0000, 32'h0043_FFFF, 32'h0050_0000, 32'h0000_0004};
      logic [4:0] te [8] = '{5'h10, 5'h10, 5'h00, 5'h08, 5'h00, 5'h04, 5'h00, 5'h04};
      for (int i = 0; i < 8; i++) begin
         go(1, ta[i]);
         chk("inner", te[i], sv(1));
         step;
         vld = 3'h0;
         step;
      end
   endtask
   task t_boot;
      go(0, 32'h000F_FFF0);
      chk("bext", 8'h02, {cs_index_o[2:0], sv(0)});
      boot_select_pin_i = 1'b1;
      step;
      chk("held", 1'b0, boot_internal_o);
      rst(1'b1);
      boot_select_pin_i = 1'b0;
      step;
      chk("bint", 1'b1, boot_internal_o);
      go(0, 32'h0000_0010);
      chk("brom", 5'h04, sv(0));
      go(0, 32'h0010_0000);
      chk("bend", 5'h00, sv(0));
      vld = 3'h0;
      remap_cmd_i = 1'b1;
      step;
      remap_cmd_i = 1'b0;
      go(0, 32'h0000_0010);
      chk("remap", 6'h30, {remap_o, sv(0)});
      vld = 3'h0;
      step;
   endtask
   task t_cs;
      chk("cfg", 4'hB, smc_cs0_cfg_o);
      cs_assign_i = 8'h3A;
      go(2, 32'h8000_0000);
      chk("ext_chip_select_7_n", 9'h17F, {sdram_chip_select_n_o, ext_chip_select_n_o});
      go(0, 32'h4000_0000);
      chk("ncs3", 9'h1F7, {sdram_chip_select_n_o, ext_chip_select_n_o});
      chk("nand", 16'h0800, {nand_enable_o, card_enable_o});
      go(0, 32'h6000_0000);
      chk("card", 16'h0020, {nand_enable_o, card_enable_o});
      go(0, 32'h2000_0000);
      chk("sdcs", 9'h0FF, {sdram_chip_select_n_o, ext_chip_select_n_o});
      cs_assign_i = 8'h00;
      #1;
      chk("ncs1", 9'h1FD, {sdram_chip_select_n_o, ext_chip_select_n_o});
      step;
      vld = 3'h0;
   endtask
   task print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         print_verdict;
      end
   end
   initial begin
      rst(1'b0);
      t_map;
      t_abort;
      t_inner;
      t_cs;
      t_boot;
      print_verdict;
   end
endmodule // bmad_matrix_decoder_bench
